/* hw/maop_core.sv */
// datapath for pointer add, AND/ADD literal and register ops, shift right
// assumes the decoder holds INSTR valid until taken; Wishbone classic slave
`timescale 1ns/1ps
module maop_core (
   input wire logic CLK,              // 40 MHz core clock
   input wire logic RST_N,            // synchronous reset, active low
   input wire logic WB_CYC_I,         // bus cycle
   input wire logic WB_STB_I,         // bus strobe
   input wire logic WB_WE_I,          // bus write
   input wire logic [7:0] WB_ADR_I,   // byte address
   input wire logic [3:0] WB_SEL_I,   // byte lanes
   input wire logic [31:0] WB_DAT_I,  // write data
   output logic [31:0] WB_DAT_O,      // read data
   output logic WB_ACK_O,             // bus acknowledge
   input wire logic INSTR_VALID,      // decoder offers an instruction
   input wire logic [13:0] INSTR,     // 14-bit instruction word
   output logic INSTR_READY,          // datapath takes an instruction
   output logic RETIRE,               // instruction completed pulse
   output logic [7:0] ACCUM,          // accumulator
   output logic [2:0] FLAGS           // {zero, digit carry, carry}
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      maop_pkg::maop_state_t st;
      logic [7:0] accum;
      logic c;
      logic dc;
      logic z;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [13:0] ir;
      logic [6:0] ea;
      logic ready;
      logic retire;
      logic ack;
      logic [31:0] dat;
   } maop_core_st_t;

   localparam maop_core_st_t ST_RST = '{
      st: maop_pkg::ST_IDLE, accum: maop_pkg::ACCUM_RST, c: 1'b0,
      dc: 1'b0, z: 1'b0, ptr0: maop_pkg::PTR_RST,
      ptr1: maop_pkg::PTR_RST, ir: 14'h0000, ea: 7'h00, ready: 1'b1,
      retire: 1'b0, ack: 1'b0, dat: maop_pkg::DAT_RST};

   maop_core_st_t s_q;
   maop_core_st_t s_d;

   // ----------------------------------------------------------------
   // decode and arithmetic helpers
   // ----------------------------------------------------------------
   function automatic maop_pkg::maop_op_t decode(input logic [13:0] i);
      logic [5:0] opc;
      opc = i[maop_pkg::OPC_HI:maop_pkg::OPC_LO];
      decode = maop_pkg::OP_NONE;
      case (opc)
         maop_pkg::OPC_PADD: begin
            // only the 0nkk kkkk half of this opcode page is ours
            if (!i[maop_pkg::PADD_ZERO_BIT]) begin
               decode = maop_pkg::OP_PADD; // [RL11]
            end
         end
         maop_pkg::OPC_ANDL: decode = maop_pkg::OP_ANDL;
         maop_pkg::OPC_ADDL: decode = maop_pkg::OP_ADDL;
         maop_pkg::OPC_ANDR: decode = maop_pkg::OP_ANDR;
         maop_pkg::OPC_ADDR: decode = maop_pkg::OP_ADDR;
         maop_pkg::OPC_ASR: decode = maop_pkg::OP_ASR;
         maop_pkg::OPC_ADDC: decode = maop_pkg::OP_ADDC;
         default: decode = maop_pkg::OP_NONE;
      endcase
   endfunction

   // returns {carry, digit carry, sum}
   function automatic logic [9:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add8 = {full[8], low[4], full[7:0]}; // [RL13]
   endfunction

   logic take;
   maop_pkg::maop_op_t new_op;
   maop_pkg::maop_op_t ex_op;
   logic [15:0] sext;
   logic [15:0] ptr0_sum;
   logic [15:0] ptr1_sum;
   logic [6:0] faddr;
   logic [6:0] ea_new;
   logic stall_new;
   logic [9:0] lit_sum;
   logic [9:0] reg_sum;
   logic [7:0] rdata;
   logic [7:0] res;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [6:0] mem_raddr;
   logic bus_req;
   logic bus_wr;

   assign take = INSTR_VALID && s_q.ready && (s_q.st == maop_pkg::ST_IDLE);
   assign new_op = decode(INSTR);
   assign ex_op = decode(s_q.ir);
   assign sext = {{10{INSTR[5]}}, INSTR[5:0]}; // [RL1]
   assign ptr0_sum = s_q.ptr0 + sext; // [RL2]
   assign ptr1_sum = s_q.ptr1 + sext; // [RL2]
   assign faddr = INSTR[6:0]; // [RL6]
   assign ea_new = (faddr == maop_pkg::IND_ADDR0) ? s_q.ptr0[6:0] :
                   (faddr == maop_pkg::IND_ADDR1) ? s_q.ptr1[6:0] : faddr;
   assign stall_new =
      ((faddr == maop_pkg::IND_ADDR0) && s_q.ptr0[maop_pkg::PTR_MSB]) ||
      ((faddr == maop_pkg::IND_ADDR1) && s_q.ptr1[maop_pkg::PTR_MSB]);
   assign lit_sum = add8(s_q.accum, INSTR[7:0], 1'b0);
   assign reg_sum = add8(s_q.accum, rdata,
                         (ex_op == maop_pkg::OP_ADDC) ? s_q.c : 1'b0); // [RL10]
   assign bus_req = WB_CYC_I && WB_STB_I;
   assign bus_wr = bus_req && WB_WE_I && s_q.ack;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.retire = 1'b0;
      mem_we = 1'b0;
      mem_wdata = 8'h00;
      mem_raddr = s_q.ea;
      res = 8'h00;
      case (s_q.st)
         maop_pkg::ST_IDLE: begin
            if (take) begin
               case (new_op)
                  maop_pkg::OP_PADD: begin
                     // status flags deliberately left alone
                     if (INSTR[maop_pkg::PADD_SEL_BIT]) begin
                        s_d.ptr1 = ptr1_sum; // [RL1]
                     end else begin
                        s_d.ptr0 = ptr0_sum; // [RL1]
                     end
                     s_d.retire = 1'b1; // [RL11]
                  end
                  maop_pkg::OP_ANDL: begin
                     s_d.accum = s_q.accum & INSTR[7:0]; // [RL3]
                     s_d.z = ((s_q.accum & INSTR[7:0]) == 8'h00); // [RL3]
                     s_d.retire = 1'b1;
                  end
                  maop_pkg::OP_ADDL: begin
                     s_d.accum = lit_sum[7:0]; // [RL4]
                     s_d.c = lit_sum[9];
                     s_d.dc = lit_sum[8];
                     s_d.z = (lit_sum[7:0] == 8'h00); // [RL13]
                     s_d.retire = 1'b1;
                  end
                  maop_pkg::OP_ANDR, maop_pkg::OP_ADDR,
                  maop_pkg::OP_ASR, maop_pkg::OP_ADDC: begin
                     s_d.ir = INSTR;
                     s_d.ea = ea_new; // [RL6]
                     mem_raddr = ea_new;
                     s_d.ready = 1'b0;
                     s_d.st = stall_new ? maop_pkg::ST_STALL
                                        : maop_pkg::ST_EXEC; // [RL12]
                  end
                  default: s_d.st = maop_pkg::ST_IDLE;
               endcase
            end
         end
         maop_pkg::ST_STALL: begin
            s_d.st = maop_pkg::ST_EXEC; // [RL12]
         end
         maop_pkg::ST_EXEC: begin
            case (ex_op)
               maop_pkg::OP_ANDR: begin
                  res = s_q.accum & rdata; // [RL7]
               end
               maop_pkg::OP_ASR: begin
                  res = {rdata[7], rdata[7:1]}; // [RL9]
                  s_d.c = rdata[0]; // [RL9]
               end
               default: begin
                  res = reg_sum[7:0]; // [RL8] [RL10]
                  s_d.c = reg_sum[9];
                  s_d.dc = reg_sum[8]; // [RL13]
               end
            endcase
            s_d.z = (res == 8'h00);
            if (s_q.ir[maop_pkg::DEST_BIT]) begin
               mem_we = 1'b1; // [RL5]
               mem_wdata = res;
            end else begin
               s_d.accum = res; // [RL5]
            end
            s_d.retire = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = maop_pkg::ST_IDLE;
         end
         default: s_d.st = maop_pkg::ST_IDLE;
      endcase

      // bus: ack one cycle after request; write lands on the ack edge,
      // after the datapath so software wins a same-cycle conflict
      s_d.ack = bus_req && !s_q.ack;
      if (bus_req && !s_q.ack && !WB_WE_I) begin
         case (WB_ADR_I)
            maop_pkg::ADR_ACCUM: s_d.dat = {24'h000000, s_q.accum};
            maop_pkg::ADR_FLAGS: s_d.dat = {29'h0, s_q.z, s_q.dc, s_q.c};
            maop_pkg::ADR_PTR0: s_d.dat = {16'h0000, s_q.ptr0};
            maop_pkg::ADR_PTR1: s_d.dat = {16'h0000, s_q.ptr1};
            maop_pkg::ADR_STATE: s_d.dat = {30'h0,
                                            s_q.st == maop_pkg::ST_STALL,
                                            s_q.ready};
            default: s_d.dat = maop_pkg::DAT_RST;
         endcase
      end
      if (bus_wr) begin
         case (WB_ADR_I)
            maop_pkg::ADR_ACCUM: begin
               if (WB_SEL_I[0]) s_d.accum = WB_DAT_I[7:0];
            end
            maop_pkg::ADR_FLAGS: begin
               if (WB_SEL_I[0]) begin
                  s_d.c = WB_DAT_I[maop_pkg::FLAG_C];
                  s_d.dc = WB_DAT_I[maop_pkg::FLAG_DC];
                  s_d.z = WB_DAT_I[maop_pkg::FLAG_Z];
               end
            end
            maop_pkg::ADR_PTR0: begin
               if (WB_SEL_I[0]) s_d.ptr0[7:0] = WB_DAT_I[7:0];
               if (WB_SEL_I[1]) s_d.ptr0[15:8] = WB_DAT_I[15:8];
            end
            maop_pkg::ADR_PTR1: begin
               if (WB_SEL_I[0]) s_d.ptr1[7:0] = WB_DAT_I[7:0];
               if (WB_SEL_I[1]) s_d.ptr1[15:8] = WB_DAT_I[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   maop_fmem u_fmem (
      .CLK(CLK),
      .rst_n(RST_N),
      .we(mem_we),
      .waddr(s_q.ea),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(rdata)
   );

   assign WB_DAT_O = s_q.dat;
   assign WB_ACK_O = s_q.ack;
   assign INSTR_READY = s_q.ready;
   assign RETIRE = s_q.retire;
   assign ACCUM = s_q.accum;
   assign FLAGS = {s_q.z, s_q.dc, s_q.c};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   logic take_reg;
   logic [8:0] sum9_lit;
   assign take_reg = take && (new_op inside {maop_pkg::OP_ANDR,
      maop_pkg::OP_ADDR, maop_pkg::OP_ASR, maop_pkg::OP_ADDC});
   assign sum9_lit = {lit_sum[9], lit_sum[7:0]};

   sequence s_fast_reg;
      take_reg && !stall_new;
   endsequence
   sequence s_slow_reg;
      take_reg && stall_new;
   endsequence

   property p_ptr_add;
      take && new_op == maop_pkg::OP_PADD && !INSTR[6] && !bus_wr
      |=> s_q.ptr0 == $past(ptr0_sum) && $stable(FLAGS);
   endproperty
   a_ptr_add: assert property (p_ptr_add) // [RL1]
      else $error("pointer add wrong or flags moved");

   property p_ptr_wrap;
      take && new_op == maop_pkg::OP_PADD && !bus_wr &&
      (INSTR[6] ? s_q.ptr1 : s_q.ptr0) == 16'hFFFF && INSTR[5:0] == 6'h01
      |=> ($past(INSTR[6]) ? s_q.ptr1 : s_q.ptr0) == 16'h0000;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) // [RL2]
      else $error("pointer did not wrap");

   property p_and_lit;
      take && new_op == maop_pkg::OP_ANDL && !bus_wr
      |=> ACCUM == ($past(s_q.accum) & $past(INSTR[7:0])) &&
          $stable(s_q.c) && $stable(s_q.dc) && RETIRE;
   endproperty
   a_and_lit: assert property (p_and_lit) // [RL3]
      else $error("literal AND result or flags wrong");

   property p_add_lit;
      take && new_op == maop_pkg::OP_ADDL && !bus_wr
      |=> {s_q.c, ACCUM} == $past(sum9_lit) && s_q.z == (ACCUM == 8'h00);
   endproperty
   a_add_lit: assert property (p_add_lit) // [RL4]
      else $error("literal add result or flags wrong");

   property p_dest;
      s_q.st == maop_pkg::ST_EXEC
      |-> mem_we == s_q.ir[maop_pkg::DEST_BIT] &&
          (!mem_we || mem_wdata == res);
   endproperty
   a_dest: assert property (p_dest) // [RL5]
      else $error("destination select wrong");

   // the accumulator must move only when the result is routed to it
   property p_dest_accum;
      s_q.st == maop_pkg::ST_EXEC && !bus_wr
      |=> ACCUM == ($past(s_q.ir[maop_pkg::DEST_BIT]) ? $past(ACCUM)
                                                      : $past(res));
   endproperty
   a_dest_accum: assert property (p_dest_accum) // [RL5]
      else $error("result routed to wrong destination");

   property p_fast;
      s_fast_reg |=> !INSTR_READY ##1 RETIRE && INSTR_READY;
   endproperty
   a_fast: assert property (p_fast) // [RL6]
      else $error("register op timing wrong");

   property p_slow;
      s_slow_reg |=> (!INSTR_READY && !RETIRE) [*2] ##1 RETIRE;
   endproperty
   a_slow: assert property (p_slow) // [RL12]
      else $error("indirect stall cycle missing");

   property p_asr;
      s_q.st == maop_pkg::ST_EXEC && ex_op == maop_pkg::OP_ASR && !bus_wr
      |=> s_q.c == $past(rdata[0]) && s_q.z == ($past(res) == 8'h00);
   endproperty
   a_asr: assert property (p_asr) // [RL9]
      else $error("shift carry or zero wrong");

   property p_padd_one;
      take && new_op == maop_pkg::OP_PADD |=> RETIRE && INSTR_READY;
   endproperty
   a_padd_one: assert property (p_padd_one) // [RL11]
      else $error("pointer add not single cycle");

endmodule

/* hw/maop_fmem.sv */
// file register memory: 128 bytes, one write and one registered read port
// assumes write and read addresses come from logic on the same clock
`timescale 1ns/1ps
module maop_fmem (
   input wire logic CLK,          // core clock
   input wire logic rst_n,        // synchronous reset, clears read data
   input wire logic we,           // write strobe
   input wire logic [6:0] waddr,  // write address
   input wire logic [7:0] wdata,  // write data
   input wire logic [6:0] raddr,  // read address
   output logic [7:0] rdata       // read data, one cycle after raddr
);
   logic [7:0] mem [0:127];

   always_ff @(posedge CLK) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

/* hw/maop_pkg.sv */
// constants, enumerations and register map of the arithmetic/logic datapath
// assumes a single 40 MHz core clock and a synchronous active-low reset
//
// Notes on behaviour
// [RL1] pointer add: sign-extended 6-bit literal, flags untouched
// [RL2] pointer is 16 bits and wraps around
// [RL3] AND literal into accumulator, zero flag only
// [RL4] add literal into accumulator, C DC Z
// [RL5] destination bit 0 accumulator, 1 file register
// [RL6] register ops take 7-bit file address
// [RL7] AND register, selected destination, zero only
// [RL8] add register, selected destination, C DC Z
// [RL9] arithmetic right shift, bit0 to carry, Z
// [RL10] add with carry, selected destination, C DC Z
// [RL11] pointer add decoded from pattern, one cycle
// [RL12] indirect access with pointer MSB costs one cycle
// [RL13] DC from bit 3, C from bit 7, Z
package maop_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_ACCUM = 8'h00;
   localparam logic [7:0] ADR_FLAGS = 8'h04;
   localparam logic [7:0] ADR_PTR0 = 8'h08;
   localparam logic [7:0] ADR_PTR1 = 8'h0C;
   localparam logic [7:0] ADR_STATE = 8'h10;

   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int STATE_READY = 0;
   localparam int STATE_STALL = 1;

   localparam logic [7:0] ACCUM_RST = 8'h00;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [31:0] DAT_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------
   localparam int OPC_HI = 13;
   localparam int OPC_LO = 8;
   localparam int DEST_BIT = 7;
   localparam int PADD_ZERO_BIT = 7;
   localparam int PADD_SEL_BIT = 6;
   localparam int PTR_MSB = 15;
   localparam logic [5:0] OPC_PADD = 6'h31;
   localparam logic [5:0] OPC_ANDL = 6'h39;
   localparam logic [5:0] OPC_ADDL = 6'h3E;
   localparam logic [5:0] OPC_ANDR = 6'h05;
   localparam logic [5:0] OPC_ADDR = 6'h07;
   localparam logic [5:0] OPC_ASR = 6'h0D;
   localparam logic [5:0] OPC_ADDC = 6'h0F;
   localparam logic [6:0] IND_ADDR0 = 7'h00;
   localparam logic [6:0] IND_ADDR1 = 7'h01;

   typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_EXEC} maop_state_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_PADD, OP_ANDL, OP_ADDL, OP_ANDR, OP_ADDR, OP_ASR, OP_ADDC
   } maop_op_t;

endpackage

/* test/maop_core_tb.sv */
// self-checking bench for the arithmetic/logic datapath
// assumes maop_dec_model drives the instruction port, Wishbone by tasks
`timescale 1ns/1ps
module maop_core_tb;
   logic CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
   logic [7:0] WB_ADR_I;
   logic [3:0] WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O;
   logic INSTR_VALID, INSTR_READY, RETIRE;
   logic [13:0] INSTR;
   logic [7:0] ACCUM;
   logic [2:0] FLAGS;
   int mismatches = 0;
   int total_checks = 0;
   logic [7:0] acc_m;
   logic [2:0] flg_m;
   logic [7:0] mem_m [128];
   logic [15:0] ptr_m [2];
   logic [5:0] ops [6] = '{maop_pkg::OPC_ANDL, maop_pkg::OPC_ADDL,
      maop_pkg::OPC_ANDR, maop_pkg::OPC_ADDR, maop_pkg::OPC_ASR,
      maop_pkg::OPC_ADDC};
   // {pointer select, start value, literal}: wraps, extremes of the literal
   logic [22:0] ptab [6] = '{{1'b0, 16'hFFFF, 6'h01},
      {1'b1, 16'h0000, 6'h20}, {1'b0, 16'h7FF0, 6'h1F},
      {1'b1, 16'h1234, 6'h00}, {1'b0, 16'h8000, 6'h05},
      {1'b1, 16'h0010, 6'h38}};

   maop_core DUT (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
      .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
      .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
      .INSTR_READY(INSTR_READY), .RETIRE(RETIRE), .ACCUM(ACCUM),
      .FLAGS(FLAGS));
   maop_dec_model dec (.CLK(CLK), .INSTR_READY(INSTR_READY),
      .INSTR_VALID(INSTR_VALID), .INSTR(INSTR));

   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   // ----------------------------------------------------------------
   // reporting
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_val(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic cmp_cyc(input string nm, input int e, input int g);
      total_checks++;
      if (g != e) begin
         mismatches++;
         $display("wrong value %s exp %0d got %0d", nm, e, g);
      end
   endtask

   // ----------------------------------------------------------------
   // expectations
   // ----------------------------------------------------------------
   function automatic logic [10:0] ref_op(input logic [5:0] opc,
      input logic [7:0] w, input logic [7:0] f, input logic [2:0] fl);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      logic [2:0] o;
      logic ci;
      logic lg;
      o = fl;
      lg = opc == maop_pkg::OPC_ANDL || opc == maop_pkg::OPC_ANDR;
      ci = (opc == maop_pkg::OPC_ADDC) ? fl[maop_pkg::FLAG_C] : 1'b0;
      s = {1'b0, w} + {1'b0, f} + {8'h00, ci};
      h = {1'b0, w[3:0]} + {1'b0, f[3:0]} + {4'h0, ci};
      r = w & f;
      if (opc == maop_pkg::OPC_ASR) begin
         r = {f[7], f[7:1]};
         o[maop_pkg::FLAG_C] = f[0];
      end else if (!lg) begin
         r = s[7:0];
         o[maop_pkg::FLAG_C] = s[8];
         o[maop_pkg::FLAG_DC] = h[4];
      end
      o[maop_pkg::FLAG_Z] = (r == 8'h00);
      return {o, r};
   endfunction

   // ----------------------------------------------------------------
   // bus and instruction tasks
   // ----------------------------------------------------------------
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= adr;
      WB_DAT_I <= wd;
      WB_SEL_I <= 4'hF;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && n < 20);
      if (n >= 20) cmp_val("bus ack", 32'h1, 32'h0);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      WB_WE_I <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] v);
      logic [31:0] rd;
      wb(1'b1, adr, v, rd);
      if (adr == maop_pkg::ADR_ACCUM) acc_m = v[7:0];
      if (adr == maop_pkg::ADR_FLAGS) flg_m = v[2:0];
      if (adr == maop_pkg::ADR_PTR0) ptr_m[0] = v[15:0];
      if (adr == maop_pkg::ADR_PTR1) ptr_m[1] = v[15:0];
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0, rd);
      cmp_val("bus read", e, rd);
   endtask

   // counts edges from the take to the retire pulse, 0 if none comes
   task automatic exec(input logic [13:0] w, input int cyc);
      int n;
      int lo;
      dec.send(w, $urandom_range(2));
      dec.done();
      n = 0;
      lo = 0;
      do begin
         @(posedge CLK);
         n++;
         if (INSTR_READY !== 1'b1) lo++;
      end while (RETIRE !== 1'b1 && n < 6);
      cmp_cyc("retire", cyc, (RETIRE === 1'b1) ? n : 0);
      cmp_cyc("ready low", (cyc > 1) ? cyc - 1 : 0, lo);
   endtask

   task automatic run_op(input int i, input logic d, input logic [7:0] x);
      logic [10:0] r;
      logic [6:0] a;
      int cyc;
      a = x[6:0];
      cyc = (i < 2) ? 1 : 2;
      if (a < 7'h02 && i >= 2) begin
         cyc = ptr_m[x[0]][15] ? 3 : 2;
         a = ptr_m[x[0]][6:0];
      end
      r = ref_op(ops[i], acc_m, (i < 2) ? x : mem_m[a], flg_m);
      flg_m = r[10:8];
      if (i < 2 || !d) acc_m = r[7:0];
      else mem_m[a] = r[7:0];
      exec({ops[i], (i < 2) ? x : {d, x[6:0]}}, cyc);
      cmp_val("accum", 32'(acc_m), 32'(ACCUM));
      cmp_val("flags", 32'(flg_m), 32'(FLAGS));
   endtask

   task automatic padd(input logic [22:0] t);
      logic [31:0] rd;
      logic [7:0] adr;
      adr = t[22] ? maop_pkg::ADR_PTR1 : maop_pkg::ADR_PTR0;
      wr(adr, 32'(t[21:6]));
      ptr_m[t[22]] = t[21:6] + {{10{t[5]}}, t[5:0]};
      exec({maop_pkg::OPC_PADD, 1'b0, t[22], t[5:0]}, 1);
      wb(1'b0, adr, 32'h0, rd);
      cmp_val("pointer", 32'(ptr_m[t[22]]), 32'(rd[15:0]));
      cmp_val("flags", 32'(flg_m), 32'(FLAGS));
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [13:0] w;
      logic [10:0] r;
      int k;
      void'($urandom(32'hBF22));
      RST_N = 1'b0;
      WB_CYC_I = 1'b0;
      WB_STB_I = 1'b0;
      WB_WE_I = 1'b0;
      WB_ADR_I = 8'h00;
      WB_SEL_I = 4'h0;
      WB_DAT_I = 32'h0;
      acc_m = 8'h00;
      flg_m = 3'h0;
      ptr_m[0] = 16'h0000;
      ptr_m[1] = 16'h0000;
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      rd_chk(maop_pkg::ADR_ACCUM, 32'h0);
      rd_chk(maop_pkg::ADR_FLAGS, 32'h0);
      rd_chk(maop_pkg::ADR_PTR0, 32'h0);
      rd_chk(maop_pkg::ADR_PTR1, 32'h0);
      rd_chk(maop_pkg::ADR_STATE, 32'h1);
      rd_chk(8'h14, 32'h0);
      wr(8'h20, 32'hFFFF_FFFF);
      wr(maop_pkg::ADR_ACCUM, $urandom());
      rd_chk(maop_pkg::ADR_ACCUM, 32'(acc_m));
      wr(maop_pkg::ADR_FLAGS, 32'h7);
      rd_chk(maop_pkg::ADR_FLAGS, 32'h7);
      // memory powers up unknown: AND with a zero accumulator clears bytes 2 to 9
      wr(maop_pkg::ADR_ACCUM, 32'h0);
      for (int f = 2; f < 10; f++) run_op(2, 1'b1, 8'(f));
      wr(maop_pkg::ADR_ACCUM, 32'h0F);
      run_op(1, 1'b0, 8'h01);
      run_op(0, 1'b0, 8'hF0);
      run_op(1, 1'b0, 8'hF0);
      run_op(5, 1'b1, 8'h02);
      run_op(4, 1'b0, 8'h02);
      run_op(0, 1'b0, 8'h00);
      // literal operations taken on consecutive edges
      for (int i = 0; i < 3; i++) begin
         w = {ops[i % 2], 8'(8'h81 + i * 8'h3C)};
         r = ref_op(w[13:8], acc_m, w[7:0], flg_m);
         acc_m = r[7:0];
         flg_m = r[10:8];
         dec.send(w, 0);
      end
      dec.done();
      @(posedge CLK);
      cmp_val("accum", 32'(acc_m), 32'(ACCUM));
      cmp_val("flags", 32'(flg_m), 32'(FLAGS));
      for (int i = 0; i < 6; i++) padd(ptab[i]);
      run_op(3, 1'b0, 8'h00);
      run_op(4, 1'b1, 8'h01);
      run_op(5, 1'b1, 8'h00);
      exec(14'h3F00, 0);
      cmp_val("accum", 32'(acc_m), 32'(ACCUM));
      exec({maop_pkg::OPC_PADD, 8'hC1}, 0);
      rd_chk(maop_pkg::ADR_PTR1, 32'(ptr_m[1]));
      for (int n = 0; n < 80; n++) begin
         if ($urandom_range(7) == 0) begin
            wr(maop_pkg::ADR_FLAGS, 32'($urandom_range(7)));
         end
         k = $urandom_range(5);
         run_op(k, 1'($urandom_range(1)),
            8'((k < 2) ? $urandom_range(255) : $urandom_range(9)));
      end
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge CLK);
      mismatches++;
      end_of_test();
   end
endmodule

/* test/maop_dec_model.sv */
// partner model: the decoder side of the instruction valid/ready port
// assumes send is entered right after a rising edge, done after the last
`timescale 1ns/1ps
module maop_dec_model (
   input wire logic CLK,           // core clock
   input wire logic INSTR_READY,   // datapath takes the word
   output logic INSTR_VALID,       // word offered
   output logic [13:0] INSTR       // instruction word
);
   initial begin
      INSTR_VALID = 1'b0;
      INSTR = 14'h0000;
   end

   // a slow decoder idles gap cycles, then holds the word until taken
   task automatic send(input logic [13:0] w, input int gap);
      repeat (gap) @(posedge CLK);
      INSTR_VALID <= 1'b1;
      INSTR <= w;
      do @(posedge CLK); while (INSTR_READY !== 1'b1);
   endtask

   // idle port shows the inverted word so a stale word is never reused
   task automatic done();
      INSTR_VALID <= 1'b0;
      INSTR <= ~INSTR;
   endtask
endmodule
